// [ssf_top.sv]
// Second-stage filter, rapid-step averaging, bypass, and calibration coefficient path.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Rapid step mode only when its bit set.
// R2: Steady inputs stay on FIR path.
// R3: Step when sample differs from second previous.
// R4: Settling flag high until FIR resumes.
// R5: Initial average 2 chop, 1 non-chop.
// R6: Averages 2x2,4x4,8x8,6x16 then FIR.
// R7: Chop step settles within two outputs.
// R8: Bypass leaves only first-stage results.
// R9: Host pairs bypass results when chopping.
// R10: Calibration starts on an op-select write with bit 2 set.
// R11: Coefficients are host readable and writable.
// R12: Offset subtracted before gain multiply.
// R13: Gain multiplies offset-corrected result.
// R14: Zero-scale to offset, full-scale to gain.
// R15: 33-bit datapath, 16 or 24 bit result.
// R16: Internal full-scale also rewrites offset.
// R17: Host does zero-scale before system full-scale.
// R18: Coefficients valid at every output rate.
// R19: Chop active when chop enable is one.
// R20: Ready line high during calibration.
// R21: Bypass overrides rapid step detection.
module ssf_top
   import ssf_pkg::*;
#(
   parameter int TAPS = SSF_FIR_TAPS
) (
   input  wire  logic                  ref_clk,        // 250 MHz clock.
   input  wire  logic                  rst,            // Asynchronous reset, active high.
   input  wire  logic [SSF_IN_W-1:0]   stage1Data,     // First-stage sinc3 output, signed.
   input  wire  logic                  stage1Valid,    // First-stage output strobe.
   input  wire  logic                  rapid_step_mode, // Rapid step enable.
   input  wire  logic                  bypassEnable,   // Second stage bypass.
   input  wire  logic                  chop_enable,    // Chop mode.
   input  wire  logic                  wordLen24,      // 1 for 24-bit, 0 for 16-bit result.
   input  wire  logic [2:0]            opSelect,       // op_select_bit2..0 value written.
   input  wire  logic                  opWrite,        // Strobe: op-select write.
   input  wire  logic                  coefSel,        // 0 offset, 1 gain coefficient.
   input  wire  logic [SSF_COEF_W-1:0] coefWrData,     // Coefficient write data.
   input  wire  logic                  coefWrite,      // Strobe: coefficient write.
   output logic [SSF_COEF_W-1:0]       coefRdData,     // Selected coefficient.
   output logic                        settling_flag,  // Moving-average path in use.
   output logic                        readyN,         // Result ready, active low.
   output logic                        calBusy,        // Calibration in progress.
   output logic [2:0]                  opState,        // Current op-select value.
   output logic [SSF_IN_W-1:0]         resultData,     // Calibrated result.
   output logic                        resultValid,    // Result available.
   input  wire  logic                  resultReady     // Host takes result.
);
   localparam int SUMW = SSF_IN_W + 5;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [TAPS-1:0][SSF_IN_W-1:0] hist;
      logic [SSF_IN_W-1:0]           prev1;
      logic [SSF_IN_W-1:0]           prev2;
      logic [1:0]                    seen;
      ssf_step_type                  step;
      logic [4:0]                    stageCnt;
      logic [4:0]                    avgLen;
      logic [SSF_COEF_W-1:0]         offsetQ;
      logic [SSF_COEF_W-1:0]         gainQ;
      ssf_cal_type                   cal;
      logic [2:0]                    op;
      logic [5:0]                    calCnt;
      logic                          calPhase;
      logic [SSF_IN_W-1:0]           filtData;
      logic                          filtValid;
      logic [SSF_COEF_W-1:0]         rdData;
      logic                          rdyN;
      logic                          calDone;
   } ssf_state_type;
   ssf_state_type s_q, s_d;

   logic [SSF_IN_W-1:0] fifoData;
   logic                fifoValid;
   logic                fifoReady;

   // ****************************************
   // Combinational helpers
   // ****************************************
   logic signed [SSF_IN_W:0]  diff;
   logic [SSF_IN_W-1:0]       absDiff;
   logic                      stepHit;
   logic signed [SUMW-1:0]    firSum;
   logic signed [SUMW-1:0]    avgSum;
   logic [SSF_IN_W-1:0]       firOut;
   logic [SSF_IN_W-1:0]       avgOut;
   logic signed [SSF_ACC_W-1:0] offCorr;
   logic signed [SSF_ACC_W+SSF_COEF_W:0] prod;
   logic [SSF_IN_W-1:0]       calOut;
   logic [SSF_IN_W-1:0]       stage2Out;

   always_comb begin
      diff    = $signed({s_q.prev2[SSF_IN_W-1], s_q.prev2}) - $signed({stage1Data[SSF_IN_W-1], stage1Data});
      absDiff = diff[SSF_IN_W] ? SSF_IN_W'(-diff) : diff[SSF_IN_W-1:0];
      stepHit = (s_q.seen == 2'h3) && (absDiff > SSF_STEP_THR); // R3
      // Boxcar FIR over TAPS samples keeps overshoot at zero.
      firSum = '0;
      avgSum = '0;
      for (int i = 0; i < TAPS; i++) begin
         firSum = firSum + SUMW'($signed(s_q.hist[i]));
         if (i < 16 && 5'(i) < s_q.avgLen) begin
            avgSum = avgSum + SUMW'($signed(s_q.hist[i]));
         end
      end
      firOut = SSF_IN_W'(firSum / SUMW'(TAPS));
      avgOut = SSF_IN_W'(avgSum / $signed(SUMW'(s_q.avgLen)));
      if (bypassEnable) begin
         stage2Out = stage1Data; // R8 R21
      end else if (s_q.step == ST_FIR) begin
         stage2Out = firOut; // R2
      end else begin
         stage2Out = avgOut; // R7
      end
      // Offset removal at 33 bits, then gain scaling at 58 bits.
      offCorr = SSF_ACC_W'($signed(s_q.filtData)) - SSF_ACC_W'($signed({1'b0, s_q.offsetQ}))
              + SSF_ACC_W'($signed({1'b0, SSF_OFFSET_RST})); // R12 R15
      prod    = (SSF_ACC_W+SSF_COEF_W+1)'(offCorr) * (SSF_ACC_W+SSF_COEF_W+1)'($signed({1'b0, s_q.gainQ})); // R13
      calOut  = SSF_IN_W'(prod >>> SSF_GAIN_SHIFT);
      if (!wordLen24) begin
         calOut[7:0] = 8'h00; // R15
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.filtValid = 1'b0;
      if (stage1Valid && s_q.cal == CAL_IDLE) begin
         s_d.hist  = {s_q.hist[TAPS-2:0], stage1Data};
         s_d.prev2 = s_q.prev1;
         s_d.prev1 = stage1Data;
         s_d.seen  = {s_q.seen[0], 1'b1};
         s_d.filtData  = stage2Out;
         s_d.filtValid = 1'b1;
         s_d.calDone   = 1'b0;
         if (!rapid_step_mode || bypassEnable) begin
            s_d.step = ST_FIR; // R1 R21
         end else if (stepHit) begin
            s_d.step     = ST_HOLD; // R3
            s_d.avgLen   = chop_enable ? SSF_N2 : 5'h01; // R5 R19
            s_d.stageCnt = '0;
         end else begin
            s_d.stageCnt = s_q.stageCnt + 5'h01;
            case (s_q.step)
               ST_FIR: s_d.stageCnt = '0;
               ST_HOLD: begin
                  s_d.step = ST_AVG2; s_d.avgLen = SSF_N2; s_d.stageCnt = 5'h01; // R6
               end
               ST_AVG2: if (s_q.stageCnt == SSF_N2) begin
                  s_d.step = ST_AVG4; s_d.avgLen = SSF_N4; s_d.stageCnt = 5'h01;
               end
               ST_AVG4: if (s_q.stageCnt == SSF_N4) begin
                  s_d.step = ST_AVG8; s_d.avgLen = SSF_N8; s_d.stageCnt = 5'h01;
               end
               ST_AVG8: if (s_q.stageCnt == SSF_N8) begin
                  s_d.step = ST_AVG16; s_d.avgLen = SSF_N16; s_d.stageCnt = 5'h01;
               end
               ST_AVG16: if (s_q.stageCnt == SSF_N16_COUNT) begin
                  s_d.step = ST_FIR; s_d.stageCnt = '0; // R4 R6
               end
               default: s_d.step = ST_FIR;
            endcase
         end
         if (s_d.step == ST_HOLD || s_q.step == ST_HOLD) begin
            if (s_d.step == ST_HOLD) s_d.stageCnt = '0;
         end
      end
      // Calibration: a new op write with bit 2 set restarts at any moment; one with bit 2 clear stops it.
      if (opWrite) begin
         s_d.op      = opSelect;
         s_d.calDone = 1'b0;
         if (opSelect[2]) begin
            s_d.cal      = CAL_RUN; // R10
            s_d.calCnt   = (opSelect == SSF_OP_IFS || opSelect == SSF_OP_SFS) ? SSF_CAL_FS_N : SSF_CAL_ZS_N;
            s_d.calPhase = 1'b0;
            s_d.rdyN     = 1'b1; // R20
         end else begin
            s_d.cal = CAL_IDLE;
         end
      end else if (s_q.cal == CAL_RUN && stage1Valid) begin
         if (s_q.calCnt == 6'h01) begin
            s_d.cal  = CAL_IDLE;
            s_d.op   = 3'h0;
            s_d.rdyN    = 1'b0; // R20
            s_d.calDone = 1'b1;
            case (s_q.op)
               SSF_OP_IZS, SSF_OP_SZS: s_d.offsetQ = stage1Data; // R14
               SSF_OP_IFS: begin
                  s_d.offsetQ = s_q.prev1; // R16
                  s_d.gainQ   = stage1Data; // R14
               end
               SSF_OP_SFS: s_d.gainQ = stage1Data; // R14 R17
               default: ;
            endcase
         end else begin
            s_d.calCnt = s_q.calCnt - 6'h01;
            s_d.prev1  = stage1Data;
         end
      end
      if (coefWrite && s_q.cal == CAL_IDLE) begin
         if (coefSel) s_d.gainQ = coefWrData; // R11 R18
         else s_d.offsetQ = coefWrData; // R11
      end
      // A finished calibration keeps ready low until the next sample or op write.
      if (fifoValid || s_d.calDone) s_d.rdyN = 1'b0; // R20
      else if (s_d.cal == CAL_IDLE && !opWrite) s_d.rdyN = 1'b1;
      if (s_d.cal == CAL_RUN) s_d.rdyN = 1'b1; // R20
      s_d.rdData = coefSel ? s_d.gainQ : s_d.offsetQ; // R11
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q         <= '0;
         s_q.step    <= ST_FIR;
         s_q.cal     <= CAL_IDLE;
         s_q.offsetQ <= SSF_OFFSET_RST;
         s_q.gainQ   <= SSF_GAIN_RST;
         s_q.avgLen  <= 5'h01;
         s_q.rdyN    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Result buffer
   // ****************************************
   ssf_fifo #(.WIDTH(SSF_IN_W), .DEPTH(SSF_FIFO_DEPTH)) uFifo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .inData   (calOut),
      .inValid  (s_q.filtValid),
      .inReady  (fifoReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (resultReady && resultValid)
   );

   // Registers resDataQ and resValidQ drive no output; a full FIFO drops the newest result, as the converter would overwrite.
   logic [SSF_IN_W-1:0] resDataQ;
   logic                resValidQ;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         resDataQ  <= '0;
         resValidQ <= 1'b0;
      end else begin
         resDataQ  <= fifoData;
         resValidQ <= fifoValid && !(resultReady && resValidQ);
      end
   end

   assign resultData    = fifoData;
   assign resultValid   = fifoValid;
   assign coefRdData    = s_q.rdData;
   assign settling_flag = (s_q.step != ST_FIR); // R4
   assign readyN        = s_q.rdyN;
   assign calBusy       = (s_q.cal == CAL_RUN);
   assign opState       = s_q.op;

   // ****************************************
   // Checks
   // ****************************************
   chk_settle_flag: assert property (@(posedge ref_clk) disable iff (rst) // R4
      $rose(settling_flag) |-> $past(stepHit && stage1Valid)) else $error("Settling flag rose without a step.");
   chk_bypass_flag: assert property (@(posedge ref_clk) disable iff (rst) // R21
      (bypassEnable && stage1Valid && s_q.cal == CAL_IDLE) |=> !settling_flag) else $error("Bypass let step in.");
   chk_step_hold: assert property (@(posedge ref_clk) disable iff (rst) // R3
      (rapid_step_mode && !bypassEnable && stage1Valid && stepHit && s_q.cal == CAL_IDLE && !opWrite)
      |=> (s_q.step == ST_HOLD)) else $error("Step not detected.");
   chk_rapid_off: assert property (@(posedge ref_clk) disable iff (rst) // R1
      (!rapid_step_mode && stage1Valid && s_q.cal == CAL_IDLE) |=> !settling_flag) else $error("Step mode when off.");
   chk_init_len: assert property (@(posedge ref_clk) disable iff (rst) // R5
      (s_q.step == ST_HOLD) |-> (s_q.avgLen == SSF_N2 || s_q.avgLen == 5'h01)) else $error("Bad initial average.");
   chk_cal_start: assert property (@(posedge ref_clk) disable iff (rst) // R10
      (opWrite && opSelect[2]) |=> (calBusy && readyN)) else $error("Calibration did not start.");
   chk_cal_ready: assert property (@(posedge ref_clk) disable iff (rst) // R20
      calBusy |-> readyN) else $error("Ready low during calibration.");
   chk_coef_write: assert property (@(posedge ref_clk) disable iff (rst) // R11
      (coefWrite && !coefSel && s_q.cal == CAL_IDLE) |=> (s_q.offsetQ == $past(coefWrData)))
      else $error("Offset write lost.");
endmodule
`default_nettype wire

// [ssf_pkg.sv]
// Package of constants and types for the second-stage filter and calibration block.
package ssf_pkg;
   localparam int          SSF_IN_W       = 24;
   localparam int          SSF_COEF_W     = 24;
   localparam int          SSF_ACC_W      = 33;
   localparam int          SSF_FIR_TAPS   = 22;
   localparam int          SSF_FIFO_DEPTH = 16;
   // Step threshold is 1 percent of full scale.
   localparam logic [23:0] SSF_STEP_THR   = 24'h028F5C;
   localparam logic [23:0] SSF_OFFSET_RST = 24'h800000;
   localparam logic [23:0] SSF_GAIN_RST   = 24'h800000;
   localparam logic [23:0] SSF_GAIN_ONE   = 24'h800000;
   localparam int          SSF_GAIN_SHIFT = 23;
   // Fixed output-count budget for each calibration conversion.
   localparam logic [5:0]  SSF_CAL_ZS_N   = 6'h16;
   localparam logic [5:0]  SSF_CAL_FS_N   = 6'h2C;
   // Operation-select codes.
   localparam logic [2:0]  SSF_OP_IZS     = 3'h4;
   localparam logic [2:0]  SSF_OP_IFS     = 3'h5;
   localparam logic [2:0]  SSF_OP_SZS     = 3'h6;
   localparam logic [2:0]  SSF_OP_SFS     = 3'h7;
   // Moving-average stage lengths and counts.
   localparam logic [4:0]  SSF_N2 = 5'h02;
   localparam logic [4:0]  SSF_N4 = 5'h04;
   localparam logic [4:0]  SSF_N8 = 5'h08;
   localparam logic [4:0]  SSF_N16_COUNT = 5'h06;
   localparam logic [4:0]  SSF_N16 = 5'h10;
   typedef enum logic [2:0] {ST_FIR, ST_HOLD, ST_AVG2, ST_AVG4, ST_AVG8, ST_AVG16} ssf_step_type;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} ssf_cal_type;
endpackage

// [ssf_fifo.sv]
// Result FIFO with parameterised width and depth.
`timescale 1ns/1ps
`default_nettype none
module ssf_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire  logic             ref_clk,  // Clock.
   input  wire  logic             rst,      // Asynchronous reset.
   input  wire  logic [WIDTH-1:0] inData,   // Write data.
   input  wire  logic             inValid,  // Write request.
   output logic                   inReady,  // Room available.
   output logic [WIDTH-1:0]       outData,  // Head word.
   output logic                   outValid, // Head valid.
   input  wire  logic             outReady  // Consumer takes head.
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } ssf_fifo_type;
   ssf_fifo_type s_q, s_d;
   logic doWr, doRd;

   assign inReady  = (s_q.cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign outValid = (s_q.cnt != '0);
   assign outData  = s_q.mem[s_q.rp];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;

   always_comb begin
      s_d = s_q;
      if (doWr) begin
         s_d.mem[s_q.wp] = inData;
         s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
      end
      if (doRd) begin
         s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
      end
      s_d.cnt = s_q.cnt + (AW+1)'(doWr) - (AW+1)'(doRd);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// [ssf_host_model.sv]
// Host-side model that reads calibrated results from the block.
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model
   import ssf_pkg::*;
(
   input  wire  logic                ref_clk,     // Clock.
   input  wire  logic                rst,         // Reset, active high.
   input  wire  logic [SSF_IN_W-1:0] resultData,  // Head result.
   input  wire  logic                resultValid, // Head valid.
   output logic                      resultReady, // Host takes head.
   input  wire  logic                stall,       // Hold off all reads.
   input  wire  logic                pairMode,    // Bypass with chopping.
   output logic [SSF_IN_W-1:0]       takenData,   // Last result taken.
   output logic                      taken,       // A result was taken.
   output logic                      pairOdd      // Next result closes a pair.
);
   int seed = 32'h9E8A;

   // Ready drops at random so the block also meets a slow reader.
   always @(negedge ref_clk or posedge rst) begin
      if (rst) begin
         resultReady <= 1'b0;
      end else begin
         resultReady <= !stall && ($random(seed) % 4 != 0);
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         taken     <= 1'b0;
         pairOdd   <= 1'b0;
         takenData <= '0;
      end else begin
         taken <= resultValid && resultReady;
         if (resultValid && resultReady) begin
            takenData <= resultData;
            // Chopped results alternate in polarity, so they are used two at a time.
            pairOdd   <= pairMode ? !pairOdd : 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb_second_stage_filter_and_calibration.sv]
// Self-checking bench for the second-stage filter and calibration block.
`timescale 1ns/1ps
`default_nettype none
module tb_second_stage_filter_and_calibration
   import ssf_pkg::*;
;
   logic                  ref_clk = 1'b0;
   logic                  rst = 1'b1;
   logic [SSF_IN_W-1:0]   stage1Data = '0;
   logic                  stage1Valid = 1'b0, rapid_step_mode = 1'b0, bypassEnable = 1'b1;
   logic                  chop_enable = 1'b1, wordLen24 = 1'b1, opWrite = 1'b0;
   logic                  coefSel = 1'b0, coefWrite = 1'b0, stall = 1'b0;
   logic [2:0]            opSelect = 3'h0, opState;
   logic [SSF_COEF_W-1:0] coefWrData = '0, coefRdData, offMdl = SSF_OFFSET_RST, gainMdl = SSF_GAIN_RST;
   logic                  settling_flag, readyN, calBusy, resultValid, resultReady, taken, pairOdd;
   logic [SSF_IN_W-1:0]   resultData, takenData, v;
   logic [SSF_IN_W-1:0]   expQ[$];
   logic [2:0]            ops[5] = '{SSF_OP_IZS, SSF_OP_SZS, SSF_OP_SFS, SSF_OP_IFS, SSF_OP_IZS};
   int                    badCount = 0, checked = 0, seed = 32'h9E8A;
   bit                    modelOn = 1'b1;

   always #2 ref_clk = ~ref_clk;

   ssf_top dut (.ref_clk(ref_clk), .rst(rst), .stage1Data(stage1Data), .stage1Valid(stage1Valid),
      .rapid_step_mode(rapid_step_mode), .bypassEnable(bypassEnable), .chop_enable(chop_enable),
      .wordLen24(wordLen24), .opSelect(opSelect), .opWrite(opWrite), .coefSel(coefSel),
      .coefWrData(coefWrData), .coefWrite(coefWrite), .coefRdData(coefRdData),
      .settling_flag(settling_flag), .readyN(readyN), .calBusy(calBusy), .opState(opState),
      .resultData(resultData), .resultValid(resultValid), .resultReady(resultReady));
   ssf_host_model host (.ref_clk(ref_clk), .rst(rst), .resultData(resultData), .resultValid(resultValid),
      .resultReady(resultReady), .stall(stall), .pairMode(bypassEnable && chop_enable),
      .takenData(takenData), .taken(taken), .pairOdd(pairOdd));

   // ****************************************
   // Shared tasks and the reference model
   // ****************************************
   task automatic chkVal(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkBit(input string what, input logic exp, input logic got);
      chkVal(what, {23'h0, exp}, {23'h0, got});
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // The offset is centred on its reset value and the gain on unity.
   function automatic logic [23:0] calib(input logic [23:0] x);
      longint r;
      r = (longint'($signed(x)) - (longint'(offMdl) - longint'(SSF_OFFSET_RST))) * longint'(gainMdl);
      r = r >>> SSF_GAIN_SHIFT;
      return wordLen24 ? r[23:0] : {r[23:8], 8'h00};
   endfunction

   task automatic send(input logic [23:0] x);
      @(negedge ref_clk);
      stage1Data = x;
      stage1Valid = 1'b1;
      if (bypassEnable && modelOn && expQ.size() < SSF_FIFO_DEPTH) expQ.push_back(calib(x));
      @(negedge ref_clk);
      stage1Valid = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic drain();
      stall = 1'b0;
      repeat (8) @(negedge ref_clk);
      for (int i = 0; i < 400 && (resultValid !== 1'b0 || expQ.size() != 0); i++) @(negedge ref_clk);
      chkVal("results left", 24'h0, 24'(expQ.size()));
   endtask

   task automatic wrCoef(input logic sel, input logic [23:0] x);
      @(negedge ref_clk);
      coefSel = sel;
      coefWrData = x;
      coefWrite = 1'b1;
      @(negedge ref_clk);
      coefWrite = 1'b0;
      if (sel) gainMdl = x;
      else offMdl = x;
   endtask

   task automatic rdCoef(input logic sel, input logic [23:0] exp);
      @(negedge ref_clk);
      coefSel = sel;
      repeat (2) @(negedge ref_clk);
      chkVal("coefficient", exp, coefRdData);
   endtask

   task automatic cal(input logic [2:0] op, input logic [23:0] x);
      int n;
      @(negedge ref_clk);
      opSelect = op;
      opWrite = 1'b1;
      @(negedge ref_clk);
      opWrite = 1'b0;
      @(negedge ref_clk);
      chkBit("ready during cal", 1'b1, readyN);
      chkBit("cal busy", 1'b1, calBusy);
      for (n = 0; n < 60 && calBusy === 1'b1; n++) send(x);
      chkVal("cal samples", 24'(op[0] ? SSF_CAL_FS_N : SSF_CAL_ZS_N), 24'(n));
      chkBit("ready after cal", 1'b0, readyN);
      chkVal("op state", 24'h0, 24'(opState));
      rdCoef(op[0], x);
   endtask

   always @(negedge ref_clk) begin
      if (taken && modelOn && expQ.size() == 0) chkVal("spare result", 24'h0, 24'hFFFFFF);
      else if (taken && modelOn) chkVal("result", expQ.pop_front(), takenData);
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      chkBit("flag in reset", 1'b0, settling_flag);
      chkBit("ready in reset", 1'b1, readyN);
      @(negedge ref_clk);
      rst = 1'b0;
      rdCoef(1'b0, SSF_OFFSET_RST);
      rdCoef(1'b1, SSF_GAIN_RST);
      rapid_step_mode = 1'b1;
      for (int m = 0; m < 4; m++) begin
         chop_enable = m[0];
         wordLen24 = m[1];
         wrCoef(1'b0, SSF_OFFSET_RST + 24'($random(seed) % 24'h10000));
         wrCoef(1'b1, 24'h400000 + 24'($unsigned($random(seed)) % 24'h400000));
         rdCoef(1'b0, offMdl);
         rdCoef(1'b1, gainMdl);
         repeat (6) send(24'h100000 + 24'($random(seed) & 32'h0FFFFF));
         chkBit("flag in bypass", 1'b0, settling_flag);
         drain();
         chkBit("pair closed", 1'b0, pairOdd);
      end
      stall = 1'b1;
      repeat (20) send(24'h100000 + 24'($random(seed) & 32'h0FFFFF));
      chkBit("fifo holds", 1'b1, resultValid);
      chkBit("ready low", 1'b0, readyN);
      drain();
      modelOn = 1'b0;
      bypassEnable = 1'b0;
      rapid_step_mode = 1'b0;
      repeat (24) send(24'h100000);
      repeat (4) send(24'h500000);
      chkBit("flag when off", 1'b0, settling_flag);
      rapid_step_mode = 1'b1;
      repeat (24) send(24'h500000);
      chkBit("flag steady", 1'b0, settling_flag);
      repeat (20) @(negedge ref_clk);
      chkVal("fir steady", calib(24'h500000), takenData);
      for (int i = 0; i < 24; i++) send(24'h100000 + 24'(i) * 24'h20000);
      chkBit("flag on ramp", 1'b1, settling_flag);
      repeat (18) send(24'h3E0000);
      chkBit("flag averaging", 1'b1, settling_flag);
      repeat (4) send(24'h3E0000);
      chkBit("flag back to fir", 1'b0, settling_flag);
      // Zero-scale precedes system full-scale and follows internal full-scale.
      foreach (ops[i]) begin
         v = 24'($random(seed));
         cal(ops[i], v);
         if (ops[i] == SSF_OP_IFS) rdCoef(1'b0, v);
      end
      drain();
      finish_test();
   end

   // The run needs about 1100 cycles; the limit of 15000 cycles allows over ten times that.
   initial begin
      #60000;
      badCount++;
      $display("[ERR] run time expected done seen timeout");
      finish_test();
   end
endmodule
`default_nettype wire
